// >>> orsg_role_swap.sv
// Role-swap tracking, negotiation timer, clock gates and APB register file
//Function
//- Default role follows plug: mini-A gives host, mini-B gives peripheral.
//- Setting B-side tracking bit enables hardware B-device peripheral-to-host assist.
//- B-side hardware handles only b_peripheral, b_wait_acon and b_host transitions.
//- Setting A-side tracking bit assists A-device host-to-peripheral switch.
//- Tracking events post sticky status bits, each maskable onto the interrupt.
//- Each controller clock is gated; enable turns it on and shows clock-on.
//- A clock stays on until software clears its enable bit.
//- Access to a controller with clock stopped ends in an error response.
//- Clearing timer run stops timer and zeroes count; flag cleared separately.
//- Timer scale code 10 gives a 1 ms tick; mode 0 is single-shot.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "orsg_params.svh"
module orsg_role_swap #(
    parameter int NCLK = 4
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [31:0]            prdata,
    // Plug and bus events
    input  wire logic              miniAPlug,
    input  wire logic              busSuspend,
    input  wire logic              peerConnect,
    input  wire logic              peerDisconnect,
    // Role and gated clocks
    output logic                   hostRole,
    output logic                   pullupDropRequest,
    output logic [NCLK-1:0]        clockGateEnable,
    output logic                   irq
);
    import orsg_pkg::*;

    orsg_state_t s_r;
    orsg_state_t s_nxt;

    function automatic logic [1:0] ctrlOfAddr(input logic [11:0] a);
        ctrlOfAddr = a[9:8];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    logic        access;
    logic        setup;
    logic        ctrlHit;
    logic        tick;
    logic        expire;
    logic        usTick;
    logic [3:0]  ev;
    logic [31:0] scRead;

    always_comb begin
        s_nxt = s_r;
        ev = 4'h0;
        setup = psel && !penable;
        access = psel && penable && s_r.pready;
        ctrlHit = paddr >= `ORSG_OFF_CTRL_WIN && paddr < `ORSG_OFF_CLK_CTRL;
        scRead = 32'h0;
        scRead[`ORSG_SC_BTRACK] = s_r.bTrack;
        scRead[`ORSG_SC_ATRACK] = s_r.aTrack;
        scRead[`ORSG_SC_SCALE_LO +: 2] = s_r.tmrScale;
        scRead[`ORSG_SC_MODE] = s_r.tmrMode;
        scRead[`ORSG_SC_RUN] = s_r.tmrRun;
        scRead[`ORSG_SC_APLUG] = s_r.aPlugLatched;
        scRead[`ORSG_SC_CNT_LO +: 16] = s_r.tmrCount;

        // Default role tracks the plug while both tracking bits are clear and no swap is under way
        if (s_r.trk == TR_IDLE && !s_r.bTrack && !s_r.aTrack) begin
            s_nxt.aPlugLatched = miniAPlug;
            s_nxt.hostRole = miniAPlug;
        end

        // Two-stage prescaler: clock cycles to 1 us, then 1 us steps to the tick;
        // a single divider would need a 21-bit product of scale and cycle count
        unique case (s_r.tmrScale)
            2'h0: s_nxt.tickTop = 14'h0001;
            2'h1: s_nxt.tickTop = 14'h000A;
            `ORSG_SCALE_1MS: s_nxt.tickTop = 14'h03E8;
            2'h3: s_nxt.tickTop = 14'h2710;
        endcase
        tick = 1'b0;
        expire = 1'b0;
        usTick = s_r.usDiv == 7'(`ORSG_US_CYCLES - 1);
        if (!s_r.tmrRun) begin
            s_nxt.tmrCount = 16'h0;
            s_nxt.usDiv = 7'h00;
            s_nxt.tickDiv = 14'h0000;
        end else begin
            s_nxt.usDiv = usTick ? 7'h00 : s_r.usDiv + 7'h01;
            if (usTick && s_r.tickDiv >= s_r.tickTop - 14'h0001) begin
                s_nxt.tickDiv = 14'h0000;
                tick = 1'b1;
            end else if (usTick) begin
                s_nxt.tickDiv = s_r.tickDiv + 14'h0001;
            end
            if (tick) begin
                if (s_r.tmrCount + 16'd1 >= s_r.tmrLoad) begin
                    expire = 1'b1;
                    s_nxt.tmrCount = 16'h0;
                    if (!s_r.tmrMode) begin
                        s_nxt.tmrRun = 1'b0;
                    end
                end else begin
                    s_nxt.tmrCount = s_r.tmrCount + 16'd1;
                end
            end
        end
        ev[`ORSG_INT_TMR] = expire;

        // Tracking sequences
        unique case (s_r.trk)
            TR_IDLE: begin
                if ((s_r.bTrack || s_r.aTrack) && busSuspend) begin
                    s_nxt.trk = TR_WAIT;
                    if (s_r.bTrack) begin
                        s_nxt.pullupDrop = 1'b1;
                        ev[`ORSG_INT_PUDROP] = 1'b1;
                    end
                end
            end
            TR_WAIT: begin
                if (peerConnect && s_r.bTrack) begin
                    s_nxt.trk = TR_DONE;
                    s_nxt.hostRole = 1'b1;
                    ev[`ORSG_INT_OK] = 1'b1;
                end else if (peerDisconnect && s_r.aTrack) begin
                    s_nxt.trk = TR_SWAP;
                end else if (!busSuspend || expire) begin
                    s_nxt.trk = TR_DONE;
                    s_nxt.pullupDrop = 1'b0;
                    ev[`ORSG_INT_FAIL] = 1'b1;
                end
            end
            TR_SWAP: begin
                s_nxt.trk = TR_DONE;
                s_nxt.hostRole = 1'b0;
                ev[`ORSG_INT_OK] = 1'b1;
            end
            TR_DONE: begin
                if (!s_r.bTrack && !s_r.aTrack) begin
                    s_nxt.trk = TR_IDLE;
                    s_nxt.pullupDrop = 1'b0;
                end
            end
        endcase

        // Clock gates follow enables one cycle later
        s_nxt.clkOn = s_r.clkEn;

        // APB
        s_nxt.pready = setup;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata = 32'h0;
        if (setup && ctrlHit && !s_r.clkOn[ctrlOfAddr(paddr)]) begin
            s_nxt.pslverr = 1'b1;
        end else if (setup && !pwrite) begin
            unique case (paddr)
                `ORSG_OFF_INT_STAT:  s_nxt.prdata = {28'h0, s_r.intStat};
                `ORSG_OFF_INT_EN:    s_nxt.prdata = {28'h0, s_r.intEn};
                `ORSG_OFF_STAT_CTRL: s_nxt.prdata = scRead;
                `ORSG_OFF_TIMER:     s_nxt.prdata = {16'h0, s_r.tmrLoad};
                `ORSG_OFF_CLK_CTRL:  s_nxt.prdata = 32'(s_r.clkEn);
                `ORSG_OFF_CLK_STAT:  s_nxt.prdata = 32'(s_r.clkOn);
                default:             s_nxt.prdata = 32'h0;
            endcase
        end
        if (access && pwrite && !s_r.pslverr) begin
            unique case (paddr)
                `ORSG_OFF_INT_EN:   s_nxt.intEn = pwdata[3:0];
                `ORSG_OFF_STAT_CTRL: begin
                    s_nxt.bTrack = pwdata[`ORSG_SC_BTRACK];
                    s_nxt.aTrack = pwdata[`ORSG_SC_ATRACK];
                    s_nxt.tmrScale = pwdata[`ORSG_SC_SCALE_LO +: 2];
                    s_nxt.tmrMode = pwdata[`ORSG_SC_MODE];
                    s_nxt.tmrRun = pwdata[`ORSG_SC_RUN];
                end
                `ORSG_OFF_TIMER:    s_nxt.tmrLoad = pwdata[15:0];
                `ORSG_OFF_CLK_CTRL: s_nxt.clkEn = pwdata[3:0];
                default: ;
            endcase
        end
        // Set wins over clear so no event is lost
        if (access && pwrite && paddr == `ORSG_OFF_INT_CLR) begin
            s_nxt.intStat = s_r.intStat & ~pwdata[3:0];
        end
        s_nxt.intStat = s_nxt.intStat | ev;
        s_nxt.irq = |(s_nxt.intStat & s_nxt.intEn);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_r <= '{trk: TR_IDLE, tickTop: 14'h0001, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign prdata = s_r.prdata;
    assign hostRole = s_r.hostRole;
    assign pullupDropRequest = s_r.pullupDrop;
    assign clockGateEnable = NCLK'(s_r.clkOn);
    assign irq = s_r.irq;

    ////////////////////////////////////////////////////////////////////////////////
    property p_plug;
        @(posedge clk) disable iff (sys_rst)
        (s_r.trk == TR_IDLE && !s_r.bTrack && !s_r.aTrack) |=> hostRole == $past(miniAPlug);
    endproperty
    a_plug: assert property (p_plug) else $error("role not from plug");

    property p_bdrop;
        @(posedge clk) disable iff (sys_rst)
        (s_r.trk == TR_IDLE && s_r.bTrack && busSuspend) |=> pullupDropRequest;
    endproperty
    a_bdrop: assert property (p_bdrop) else $error("no pull-up drop");

    property p_bhost;
        @(posedge clk) disable iff (sys_rst)
        (s_r.trk == TR_WAIT && s_r.bTrack && peerConnect) |=> hostRole;
    endproperty
    a_bhost: assert property (p_bhost) else $error("b side not host");

    property p_aswap;
        @(posedge clk) disable iff (sys_rst)
        (s_r.trk == TR_SWAP) |=> !hostRole && s_r.intStat[`ORSG_INT_OK];
    endproperty
    a_aswap: assert property (p_aswap) else $error("a side swap wrong");

    property p_irq;
        @(posedge clk) disable iff (sys_rst)
        irq == (|(s_r.intStat & s_r.intEn));
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_clkon;
        @(posedge clk) disable iff (sys_rst)
        $rose(s_r.clkEn[0]) |=> s_r.clkOn[0] ##0 clockGateEnable[0];
    endproperty
    a_clkon: assert property (p_clkon) else $error("clock-on late");

    property p_hold;
        @(posedge clk) disable iff (sys_rst)
        (s_r.clkOn[0] && s_r.clkEn[0]) |=> s_r.clkOn[0];
    endproperty
    a_hold: assert property (p_hold) else $error("clock dropped");

    property p_err;
        @(posedge clk) disable iff (sys_rst)
        (psel && !penable && ctrlHit && !s_r.clkOn[ctrlOfAddr(paddr)]) |=> pslverr && pready;
    endproperty
    a_err: assert property (p_err) else $error("no error response");

    property p_stop;
        @(posedge clk) disable iff (sys_rst)
        !s_r.tmrRun |=> s_r.tmrCount == 16'h0;
    endproperty
    a_stop: assert property (p_stop) else $error("count not zeroed");

    property p_once;
        @(posedge clk) disable iff (sys_rst)
        (s_r.trk == TR_DONE) |=> !ev[`ORSG_INT_OK] && !ev[`ORSG_INT_FAIL];
    endproperty
    a_once: assert property (p_once) else $error("extra track event");

    property p_fail;
        @(posedge clk) disable iff (sys_rst)
        (s_r.trk == TR_WAIT && !busSuspend && !peerConnect && !peerDisconnect)
            |=> s_r.intStat[`ORSG_INT_FAIL] && !pullupDropRequest;
    endproperty
    a_fail: assert property (p_fail) else $error("no failure flag");

    property p_tmrflag;
        @(posedge clk) disable iff (sys_rst)
        expire |=> s_r.intStat[`ORSG_INT_TMR];
    endproperty
    a_tmrflag: assert property (p_tmrflag) else $error("timer flag missing");
endmodule

// >>> orsg_params.svh
// Register offsets, field positions, scale code and timing counts for the role-swap block
`ifndef ORSG_PARAMS_SVH
`define ORSG_PARAMS_SVH

`define ORSG_OFF_INT_STAT    12'h000
`define ORSG_OFF_INT_EN      12'h004
`define ORSG_OFF_INT_SET     12'h00C
`define ORSG_OFF_INT_CLR     12'h008
`define ORSG_OFF_STAT_CTRL   12'h010
`define ORSG_OFF_TIMER       12'h014
`define ORSG_OFF_CLK_CTRL    12'hFF4
`define ORSG_OFF_CLK_STAT    12'hFF8
`define ORSG_OFF_CTRL_WIN    12'h100

// Interrupt bit positions
`define ORSG_INT_TMR         0
`define ORSG_INT_PUDROP      1
`define ORSG_INT_OK          2
`define ORSG_INT_FAIL        3

// Status/control bit positions
`define ORSG_SC_BTRACK       0
`define ORSG_SC_ATRACK       1
`define ORSG_SC_SCALE_LO     2
`define ORSG_SC_MODE         4
`define ORSG_SC_RUN          5
`define ORSG_SC_APLUG        6
`define ORSG_SC_CNT_LO       16

`define ORSG_SCALE_1MS       2'h2
`define ORSG_TICK_1US_NS     1000
`define ORSG_CLK_NS          8
`define ORSG_US_CYCLES       (`ORSG_TICK_1US_NS / `ORSG_CLK_NS)

`endif

// >>> orsg_pkg.sv
// Types for the role-swap assist and clock gate block
package orsg_pkg;
    typedef enum logic [3:0] {
        TR_IDLE = 4'b0001,
        TR_WAIT = 4'b0010,
        TR_SWAP = 4'b0100,
        TR_DONE = 4'b1000
    } orsg_track_t;

    typedef struct packed {
        logic [3:0]  intStat;
        logic [3:0]  intEn;
        logic        bTrack;
        logic        aTrack;
        logic [1:0]  tmrScale;
        logic        tmrMode;
        logic        tmrRun;
        logic        aPlugLatched;
        logic [15:0] tmrLoad;
        logic [15:0] tmrCount;
        logic [6:0]  usDiv;
        logic [13:0] tickDiv;
        logic [13:0] tickTop;
        logic [3:0]  clkEn;
        logic [3:0]  clkOn;
        orsg_track_t trk;
        logic        pullupDrop;
        logic        hostRole;
        logic        irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } orsg_state_t;
endpackage

// >>> orsg_peer_model.sv
// Behavioural model of the transceiver and peer dual-role device
`timescale 1ns/1ns
module orsg_peer_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Scenario controls
    input  wire logic       plugA,
    input  wire logic       suspendOn,
    input  wire logic [1:0] answerKind,
    // Link side of the block
    input  wire logic       pullupDropRequest,
    output logic            miniAPlug = 1'b0,
    output logic            busSuspend = 1'b0,
    output logic            peerConnect = 1'b0,
    output logic            peerDisconnect = 1'b0
);
    logic [7:0] waitCnt = 8'h00;
    ////////////////////////////////////////////////////////////////////////////////
    // Plug stays inserted through reset, so it is not cleared there
    always @(posedge clk) begin
        miniAPlug <= plugA;
        busSuspend <= suspendOn;
        if (sys_rst || !busSuspend) begin
            waitCnt <= 8'h00;
        end else if (waitCnt != 8'hFF) begin
            waitCnt <= waitCnt + 8'h01;
        end
        // Peer answers slowly; it connects only after the pull-up is gone
        peerConnect <= !sys_rst && answerKind == 2'h1 && busSuspend
                       && pullupDropRequest && waitCnt >= 8'h05;
        peerDisconnect <= !sys_rst && answerKind == 2'h2 && busSuspend
                          && waitCnt >= 8'h05;
    end
endmodule

// >>> testbench.sv
// Register-level bench for the role-swap and clock gate block
`timescale 1ns/1ns
`include "orsg_params.svh"
module testbench;
    logic        clk = 1'b0;
    logic        sysRst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        pready, pslverr, hostRole, pullupDropRequest, irq, rerr;
    logic [31:0] prdata, rdata;
    logic [3:0]  clockGateEnable;
    logic        miniAPlug, busSuspend, peerConnect, peerDisconnect;
    logic        plugA = 1'b0;
    logic        suspendOn = 1'b0;
    logic [1:0]  answerKind = 2'h0;
    logic [11:0] win;
    int          badCount = 0;
    int          numChecks = 0;
    int          cycles = 0;

    initial begin
        forever #4 clk = ~clk;
    end

    orsg_role_swap uut (.clk, .sys_rst(sysRst), .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .pslverr, .prdata, .miniAPlug, .busSuspend, .peerConnect,
        .peerDisconnect, .hostRole, .pullupDropRequest, .clockGateEnable, .irq);
    orsg_peer_model peer (.clk, .sys_rst(sysRst), .plugA, .suspendOn, .answerKind,
        .pullupDropRequest, .miniAPlug, .busSuspend, .peerConnect, .peerDisconnect);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // A hung handshake ends here rather than running forever
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One idle edge before each setup keeps psel from being assigned twice
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask

    task automatic waitReg(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while ((rdata & m) !== v && n < 1000);
        chk(rdata & m, v);
    endtask

    task automatic doReset(input logic plug);
        @(posedge clk);
        plugA <= plug;
        sysRst <= 1'b1;
        suspendOn <= 1'b0;
        answerKind <= 2'h0;
        repeat (5) @(posedge clk);
        sysRst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        doReset(1'b0);
        chk(hostRole, 1'b0);
        rdc(`ORSG_OFF_STAT_CTRL, 32'h0);
        rdc(12'h020, 32'h0);
        chk(rerr, 1'b0);
        apb(1'b1, `ORSG_OFF_INT_STAT, 32'hF);
        rdc(`ORSG_OFF_INT_STAT, 32'h0);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            win = 12'(12'h400 + 256 * i);
            apb(1'b0, win, 32'h0);
            chk(rerr, 1'b1);
            apb(1'b1, `ORSG_OFF_CLK_CTRL, 32'(1 << i));
            waitReg(`ORSG_OFF_CLK_STAT, 32'hF, 32'(1 << i));
            chk(clockGateEnable, 32'(1 << i));
            apb(1'b0, win, 32'h0);
            chk(rerr, 1'b0);
            repeat (40) @(posedge clk);
            rdc(`ORSG_OFF_CLK_STAT, 32'(1 << i));
            apb(1'b1, `ORSG_OFF_CLK_CTRL, 32'h0);
            waitReg(`ORSG_OFF_CLK_STAT, 32'hF, 32'h0);
        end
        $display("test clock gates done");
        apb(1'b1, `ORSG_OFF_INT_EN, 32'hF);
        apb(1'b1, `ORSG_OFF_STAT_CTRL, 32'h1);
        answerKind <= 2'h1;
        suspendOn <= 1'b1;
        waitReg(`ORSG_OFF_INT_STAT, 32'h4, 32'h4);
        rdc(`ORSG_OFF_INT_STAT, 32'h6);
        chk(hostRole, 1'b1);
        chk(irq, 1'b1);
        apb(1'b1, `ORSG_OFF_INT_EN, 32'h0);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        apb(1'b1, `ORSG_OFF_INT_CLR, 32'hF);
        repeat (30) @(posedge clk);
        rdc(`ORSG_OFF_INT_STAT, 32'h0);
        $display("test b-side swap done");
        doReset(1'b0);
        apb(1'b1, `ORSG_OFF_STAT_CTRL, 32'h1);
        suspendOn <= 1'b1;
        waitReg(`ORSG_OFF_INT_STAT, 32'h2, 32'h2);
        chk(pullupDropRequest, 1'b1);
        suspendOn <= 1'b0;
        waitReg(`ORSG_OFF_INT_STAT, 32'h8, 32'h8);
        rdc(`ORSG_OFF_INT_STAT, 32'hA);
        chk(hostRole, 1'b0);
        $display("test b-side failure done");
        doReset(1'b1);
        chk(hostRole, 1'b1);
        rdc(`ORSG_OFF_STAT_CTRL, 32'h40);
        apb(1'b1, `ORSG_OFF_STAT_CTRL, 32'h2);
        answerKind <= 2'h2;
        suspendOn <= 1'b1;
        waitReg(`ORSG_OFF_INT_STAT, 32'h4, 32'h4);
        rdc(`ORSG_OFF_INT_STAT, 32'h4);
        chk(hostRole, 1'b0);
        $display("test a-side swap done");
        doReset(1'b0);
        apb(1'b1, `ORSG_OFF_TIMER, 32'h3);
        apb(1'b1, `ORSG_OFF_STAT_CTRL, 32'h20);
        waitReg(`ORSG_OFF_INT_STAT, 32'h1, 32'h1);
        apb(1'b1, `ORSG_OFF_INT_CLR, 32'h1);
        repeat (800) @(posedge clk);
        rdc(`ORSG_OFF_INT_STAT, 32'h0);
        rdc(`ORSG_OFF_STAT_CTRL, 32'h0);
        apb(1'b1, `ORSG_OFF_TIMER, 32'h64);
        apb(1'b1, `ORSG_OFF_STAT_CTRL, 32'h20);
        waitReg(`ORSG_OFF_STAT_CTRL, 32'hFFFF0000, 32'h00020000);
        apb(1'b1, `ORSG_OFF_STAT_CTRL, 32'h0);
        rdc(`ORSG_OFF_STAT_CTRL, 32'h0);
        apb(1'b1, `ORSG_OFF_TIMER, 32'hC8);
        apb(1'b1, `ORSG_OFF_STAT_CTRL, 32'h28);
        repeat (500) @(posedge clk);
        rdc(`ORSG_OFF_STAT_CTRL, 32'h28);
        rdc(`ORSG_OFF_INT_STAT, 32'h0);
        $display("test timer done");
        finish_test();
    end
endmodule
